// [hdl/cabc_bus_ctrl.sv]
// Purpose: processor side asynchronous bus cycle control
// Assumes: user side issues one request at a time, held until done
// Notes:   tri-state pins are split into out and enable-low
// Operation
// - drive 23-bit address during every cycle, interrupt acknowledge included
// - interrupt acknowledge places serviced level on A1..A3
// - 16-bit bidirectional data, word or byte transfers
// - address strobe low only while address is valid
// - direction high for read, low for write; devices drive on read
// - byte strobes with direction mark valid byte lanes
// - accept interrupt requests at seven priority levels
// - encoded level, seven highest, zero means no request
// - bus signals shared by private, system and hardware buses
// - decode exactly one device select from the current address, none during interrupt acknowledge
`timescale 1ns/100ps
module cabc_bus_ctrl #(
	parameter int SEL_N = cabc_pkg::NUM_SELECTS
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        rstn_i,
	input  wire logic                        req_i,
	input  wire logic                        req_rd_i,
	input  wire logic                        req_iack_i,
	input  wire logic [cabc_pkg::ADDR_W-1:0] req_addr_i,
	input  wire logic [1:0]                  req_lanes_i,
	input  wire logic [cabc_pkg::DATA_W-1:0] req_wdata_i,
	output logic                             done_o,
	output logic [cabc_pkg::DATA_W-1:0]      rdata_o,
	output logic [2:0]                       irq_level_o,
	input  wire logic                        transfer_acknowledge_n_i,
	input  wire logic [2:0]                  irq_n_i,
	input  wire logic [cabc_pkg::DATA_W-1:0] data_i,
	output logic [cabc_pkg::DATA_W-1:0]      data_o,
	output logic                             data_oe_n_o,
	output logic [cabc_pkg::ADDR_W-1:0]      addr_o,
	output logic                             addr_oe_n_o,
	output logic                             address_valid_strobe_n_o,
	output logic                             read_write_n_o,
	output logic                             upper_byte_strobe_n_o,
	output logic                             lower_byte_strobe_n_o,
	output logic                             processor_clock_line_o,
	output logic [SEL_N-1:0]                 dev_select_n_o
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic [SEL_N-1:0] sel_decode(
		input logic [cabc_pkg::ADDR_W-1:0] a,
		input logic                        en);
		logic [SEL_N-1:0] s;
		// upper address bits pick the device, wrapping on the select count
		s = '1;
		if (en) begin
			s[int'(a[cabc_pkg::ADDR_W-1:cabc_pkg::SEL_SHIFT]) % SEL_N] = 1'b0;
		end
		return s;
	endfunction : sel_decode

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// read data is not synchronised: it has settled long before the
	// acknowledge has crossed the three stages
	cabc_sync_if sy ();

	cabc_pin_sync u_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.ack_n_i    (transfer_acknowledge_n_i),
		.irq_n_i    (irq_n_i),
		.sync       (sy)
	);

	// ------------------------------------------------------------
	// cycle state
	// ------------------------------------------------------------
	cabc_pkg::cabc_state_type   st_r, st_nxt;
	logic [cabc_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [cabc_pkg::DATA_W-1:0] dout_r, dout_nxt, rdata_r, rdata_nxt;
	logic                        aoe_n_r, aoe_n_nxt, doe_n_r, doe_n_nxt;
	logic                        as_n_r, as_n_nxt, rw_r, rw_nxt;
	logic                        uds_n_r, uds_n_nxt, lds_n_r, lds_n_nxt;
	// the clock line runs free at half the core clock
	logic                        done_r, done_nxt, pclk_r, pclk_nxt;
	logic [2:0]                  irq_r, irq_nxt;
	logic [SEL_N-1:0]            sel_r, sel_nxt;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		addr_nxt  = addr_r;
		dout_nxt  = dout_r;
		rdata_nxt = rdata_r;
		aoe_n_nxt = aoe_n_r;
		doe_n_nxt = doe_n_r;
		as_n_nxt  = as_n_r;
		rw_nxt    = rw_r;
		uds_n_nxt = uds_n_r;
		lds_n_nxt = lds_n_r;
		done_nxt  = 1'b0;
		pclk_nxt  = ~pclk_r;
		irq_nxt   = sy.irq_lvl;
		sel_nxt   = sel_r;
		case (st_r)
			cabc_pkg::ST_IDLE: begin
				// a new cycle waits until the last acknowledge is seen
				// released, else a stale low ends the next cycle early
				if (req_i && !done_r && sy.ack_n) begin
					aoe_n_nxt = 1'b0;
					// interrupt acknowledge is a read cycle
					rw_nxt    = req_rd_i | req_iack_i;
					if (req_iack_i) begin
						// bit 0 of the bus is A1, so the level fills 2:0
						addr_nxt = {{(cabc_pkg::ADDR_W-3){1'b1}},
							irq_r};
					end else begin
						addr_nxt = req_addr_i;
					end
					st_nxt = cabc_pkg::ST_ADDR;
				end
			end
			cabc_pkg::ST_ADDR: begin
				// selects follow a settled address, never a half-set one
				as_n_nxt = 1'b0;
				sel_nxt  = sel_decode(addr_r, !req_iack_i);
				if (!rw_r) begin
					dout_nxt  = req_wdata_i;
					doe_n_nxt = 1'b0;
				end
				st_nxt = cabc_pkg::ST_STRB;
			end
			cabc_pkg::ST_STRB: begin
				// byte strobes one cycle after the address strobe
				uds_n_nxt = ~(req_lanes_i[1] | req_iack_i);
				lds_n_nxt = ~(req_lanes_i[0] | req_iack_i);
				st_nxt    = cabc_pkg::ST_WAIT;
			end
			cabc_pkg::ST_WAIT: begin
				if (!sy.ack_n) begin
					// read data taken in the cycle the acknowledge shows
					if (rw_r) begin
						rdata_nxt = data_i;
					end
					st_nxt = cabc_pkg::ST_END;
				end
			end
			cabc_pkg::ST_END: begin
				// all released together; done pulses for one cycle
				as_n_nxt  = 1'b1;
				uds_n_nxt = 1'b1;
				lds_n_nxt = 1'b1;
				doe_n_nxt = 1'b1;
				aoe_n_nxt = 1'b1;
				sel_nxt   = '1;
				rw_nxt    = 1'b1;
				done_nxt  = 1'b1;
				st_nxt    = cabc_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = cabc_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r    <= cabc_pkg::ST_IDLE;
			addr_r  <= cabc_pkg::ADDR_RST;
			dout_r  <= cabc_pkg::DATA_RST;
			rdata_r <= cabc_pkg::DATA_RST;
			aoe_n_r <= 1'b1;
			doe_n_r <= 1'b1;
			as_n_r  <= 1'b1;
			rw_r    <= 1'b1;
			uds_n_r <= 1'b1;
			lds_n_r <= 1'b1;
			done_r  <= 1'b0;
			pclk_r  <= 1'b0;
			irq_r   <= 3'h0;
			sel_r   <= '1;
		end else begin
			st_r    <= st_nxt;
			addr_r  <= addr_nxt;
			dout_r  <= dout_nxt;
			rdata_r <= rdata_nxt;
			aoe_n_r <= aoe_n_nxt;
			doe_n_r <= doe_n_nxt;
			as_n_r  <= as_n_nxt;
			rw_r    <= rw_nxt;
			uds_n_r <= uds_n_nxt;
			lds_n_r <= lds_n_nxt;
			done_r  <= done_nxt;
			pclk_r  <= pclk_nxt;
			irq_r   <= irq_nxt;
			sel_r   <= sel_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// every output is a plain copy of a flop
	assign done_o                   = done_r;
	assign rdata_o                  = rdata_r;
	assign irq_level_o              = irq_r;
	assign data_o                   = dout_r;
	assign data_oe_n_o              = doe_n_r;
	assign addr_o                   = addr_r;
	assign addr_oe_n_o              = aoe_n_r;
	assign address_valid_strobe_n_o = as_n_r;
	assign read_write_n_o           = rw_r;
	assign upper_byte_strobe_n_o    = uds_n_r;
	assign lower_byte_strobe_n_o    = lds_n_r;
	assign processor_clock_line_o   = pclk_r;
	assign dev_select_n_o           = sel_r;
endmodule : cabc_bus_ctrl

// [hdl/cabc_pkg.sv]
// Purpose: shared constants and types for the processor bus cycle controller
// Assumes: 20 MHz core clock, 23-bit word address, 16-bit data path
// Notes:   timing is counted in core clock cycles
package cabc_pkg;
	localparam int ADDR_W        = 23;
	localparam int DATA_W        = 16;
	localparam int IRQ_W         = 3;
	localparam int SYNC_STAGES   = 3;
	localparam int NUM_SELECTS   = 4;
	localparam int SEL_SHIFT     = 20;
	localparam int CLK_HZ        = 20000000;
	localparam int PCLK_HALF_CYC = 1;
	localparam logic [22:0] ADDR_RST   = 23'h000000;
	localparam logic [15:0] DATA_RST   = 16'h0000;
	localparam logic [2:0]  IACK_FIELD = 3'h7;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_ADDR  = 5'h02,
		ST_STRB  = 5'h04,
		ST_WAIT  = 5'h08,
		ST_END   = 5'h10
	} cabc_state_type;
endpackage : cabc_pkg

// [hdl/cabc_sync_if.sv]
// Purpose: carries synchronised pin levels between controller modules
// Assumes: one clock domain
// Notes:   plain levels, no handshake
`timescale 1ns/100ps
interface cabc_sync_if;
	logic       ack_n;
	logic [2:0] irq_lvl;
	modport src (output ack_n, output irq_lvl);
	modport dst (input ack_n, input irq_lvl);
endinterface : cabc_sync_if

// [hdl/cabc_pin_sync.sv]
// Purpose: three-stage synchroniser for acknowledge and interrupt pins
// Assumes: pins are asynchronous to core_clk_i
// Notes:   a change counts once stages two and three agree
`timescale 1ns/100ps
module cabc_pin_sync (
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       ack_n_i,
	input  wire logic [2:0] irq_n_i,
	cabc_sync_if.src        sync
);
	logic [3:0] s1_r, s2_r, s3_r, q_r;
	logic [3:0] q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (s2_r == s3_r) begin
			q_nxt = s3_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_r <= 4'hF;
			s2_r <= 4'hF;
			s3_r <= 4'hF;
			q_r  <= 4'hF;
		end else begin
			s1_r <= {ack_n_i, irq_n_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	// pins are active low; level zero after inversion means no request
	assign sync.ack_n   = q_r[3];
	assign sync.irq_lvl = ~q_r[2:0];
endmodule : cabc_pin_sync

// [verif/cabc_bus_ctrl_asserts.sv]
// Purpose: bus cycle protocol checks
// Assumes: single core clock
// Notes:   bound into cabc_bus_ctrl
`timescale 1ns/100ps
module cabc_bus_ctrl_asserts #(parameter int SEL_N = 4) (
	input wire logic             core_clk_i,
	input wire logic             rstn_i,
	input wire logic             req_iack_i,
	input wire logic [1:0]       req_lanes_i,
	input wire logic             transfer_acknowledge_n_i,
	input wire logic             done_o,
	input wire logic             data_oe_n_o,
	input wire logic             address_valid_strobe_n_o,
	input wire logic             read_write_n_o,
	input wire logic             upper_byte_strobe_n_o,
	input wire logic             lower_byte_strobe_n_o,
	input wire logic [SEL_N-1:0] dev_select_n_o,
	input wire logic             addr_oe_n_o,
	input wire logic             processor_clock_line_o
);
	// --------
	// checks
	// --------
	wire as_n = address_valid_strobe_n_o;
	wire s_n = upper_byte_strobe_n_o & lower_byte_strobe_n_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	strb_qual_a: assert property (!s_n |-> !as_n)
		else $error("data strobe without address strobe");
	sel_idle_a: assert property (as_n |-> &dev_select_n_o)
		else $error("select while idle");
	sel_one_a: assert property (!as_n && !req_iack_i |->
		$onehot(~dev_select_n_o)) else $error("select not one-hot");
	iack_sel_a: assert property (req_iack_i |-> &dev_select_n_o)
		else $error("select in acknowledge cycle");
	drv_write_a: assert property (!data_oe_n_o |-> !read_write_n_o)
		else $error("data driven on read");
	lane_map_a: assert property ($fell(as_n) && !req_iack_i |=>
		{upper_byte_strobe_n_o, lower_byte_strobe_n_o} == ~req_lanes_i)
		else $error("byte strobes wrong");
	ack_first_a: assert property (done_o |->
		!$past(transfer_acknowledge_n_i, 2)) else $error("done before ack");
	done_one_a: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	addr_drv_a: assert property (!as_n |-> !addr_oe_n_o)
		else $error("address strobe without driven address");
	pclk_tog_a: assert property ($past(rstn_i) |->
		processor_clock_line_o != $past(processor_clock_line_o))
		else $error("processor clock line stuck");
	cover property (!as_n && read_write_n_o);
	cover property (!data_oe_n_o);
	cover property (!as_n && req_iack_i);
endmodule : cabc_bus_ctrl_asserts
bind cabc_bus_ctrl cabc_bus_ctrl_asserts #(.SEL_N(SEL_N))
	i_cabc_bus_ctrl_asserts (.*);

// [verif/cabc_dev_model.sv]
// Purpose: one-word memory answering on the processor bus
// Assumes: acknowledge held low until both byte strobes rise
// Notes:   wait_i sets how long the answer takes
`timescale 1ns/100ps
module cabc_dev_model (
	input  wire logic        core_clk_i,
	input  wire logic        uds_n_i,
	input  wire logic        lds_n_i,
	input  wire logic        rw_i,
	input  wire logic [15:0] d_i,
	input  wire logic [4:0]  wait_i,
	output logic             ack_n_o,
	output logic [15:0]      q_o
);
	// --------
	// device
	// --------
	logic [4:0]  cnt_r = 5'h00;
	logic [15:0] mem_r = 16'h0000;
	initial ack_n_o = 1'b1;
	initial q_o = 16'h3C3C;
	always @(posedge core_clk_i) begin
		if (uds_n_i && lds_n_i) begin
			cnt_r <= 5'h00;
			ack_n_o <= 1'b1;
			q_o <= ~q_o; // released bus must not show stale data
		end else begin
			cnt_r <= cnt_r + 5'h01;
			if (cnt_r == wait_i) ack_n_o <= 1'b0;
			if (rw_i) q_o <= mem_r;
			if (!rw_i && cnt_r == 5'h00)
				mem_r <= {uds_n_i ? mem_r[15:8] : d_i[15:8],
					lds_n_i ? mem_r[7:0] : d_i[7:0]};
		end
	end
endmodule : cabc_dev_model

// [verif/tb_cabc_bus_ctrl.sv]
// Purpose: self-checking bench for the bus cycle controller
// Assumes: partner model answers after wait_r cycles
// Notes:   select count left at package default
`timescale 1ns/100ps
module tb_cabc_bus_ctrl;
	logic core_clk_i = 1'b0, rstn_i = 1'b0, req_i, req_rd_i, req_iack_i;
	logic [22:0] req_addr_i, addr_o, a_seen;
	logic [15:0] req_wdata_i, rdata_o, data_i, data_o, dev_q;
	logic [1:0] req_lanes_i;
	logic [2:0] irq_n_i, irq_level_o;
	logic [4:0] wait_r;
	logic [cabc_pkg::NUM_SELECTS-1:0] dev_select_n_o, s_seen;
	logic done_o, data_oe_n_o, addr_oe_n_o, transfer_acknowledge_n_i;
	logic address_valid_strobe_n_o, read_write_n_o, processor_clock_line_o;
	logic upper_byte_strobe_n_o, lower_byte_strobe_n_o;
	int bad_count = 0, n_compared = 0;
	assign data_i = data_oe_n_o ? dev_q : data_o;
	cabc_bus_ctrl i_cabc_bus_ctrl (.*);
	cabc_dev_model i_cabc_dev_model (.core_clk_i, .uds_n_i(upper_byte_strobe_n_o),
		.lds_n_i(lower_byte_strobe_n_o), .rw_i(read_write_n_o), .d_i(data_i),
		.wait_i(wait_r), .ack_n_o(transfer_acknowledge_n_i), .q_o(dev_q));
	// --------
	// tasks
	// --------
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [22:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : cmp
	task automatic cyc(input logic rd, ia, input logic [22:0] a,
		input logic [1:0] ln, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge core_clk_i);
		{req_i, req_rd_i, req_iack_i} <= {1'b1, rd, ia};
		{req_addr_i, req_lanes_i, req_wdata_i} <= {a, ln, wd};
		do begin
			@(posedge core_clk_i);
			#1;
			if (!address_valid_strobe_n_o) {a_seen, s_seen} = {addr_o, dev_select_n_o};
			n++;
		end while (done_o !== 1'b1 && n < 300);
		if (n >= 300) begin
			cmp(1'b0, 1'b1, "no done");
			finish_test();
		end
		@(posedge core_clk_i);
		req_i <= 1'b0; // drop at the edge where done is ignored
	endtask : cyc
	task automatic t_rw;
		cyc(0, 0, 23'h000010, 2'h3, 16'hA5C3);
		cyc(1, 0, 23'h000010, 2'h3, 16'h0000);
		cmp(rdata_o, 16'hA5C3, "word");
		wait_r <= 5'h0C;
		cyc(0, 0, 23'h000010, 2'h2, 16'h5A00);
		cyc(0, 0, 23'h000010, 2'h1, 16'hFF3C);
		cyc(1, 0, 23'h000010, 2'h3, 16'h0000);
		cmp(rdata_o, 16'h5A3C, "lanes");
		wait_r <= 5'h02;
	endtask : t_rw
	task automatic t_sel;
		logic [cabc_pkg::NUM_SELECTS-1:0] e;
		for (int i = 0; i < 8; i++) begin
			e = '1;
			e[i % cabc_pkg::NUM_SELECTS] = 1'b0;
			cyc(1, 0, {i[2:0], 20'h00002}, 2'h3, 16'h0000);
			cmp(s_seen, e, "select");
			cmp(a_seen, {i[2:0], 20'h00002}, "address");
		end
	endtask : t_sel
	task automatic t_irq;
		for (int l = 0; l < 8; l++) begin
			irq_n_i <= ~l[2:0];
			repeat (6) @(posedge core_clk_i);
			cmp(irq_level_o, l[2:0], "level");
			cyc(1, 1, 23'h000000, 2'h3, 16'h0000);
			cmp(a_seen, {20'hFFFFF, l[2:0]}, "iack address");
		end
	endtask : t_irq
	initial forever #25 core_clk_i = ~core_clk_i;
	initial begin
		{req_i, req_rd_i, req_iack_i, req_lanes_i} = 5'h00;
		{req_addr_i, req_wdata_i, irq_n_i, wait_r} = {39'h0, 3'h7, 5'h02};
		repeat (3) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_rw();
		t_sel();
		t_irq();
		finish_test();
	end
endmodule : tb_cabc_bus_ctrl
